// ===== test/core_model.sv
// partner model: the processor core making special-function accesses
// assumes the block takes its inputs on the rising edge of mclk_i
`timescale 1ns/1ps
`default_nettype none
module core_model (
    // clock
    input wire logic mclk_i,
    // special-function access
    output var wd_mem_pkg::sfr_req_t sfr_req_o,
    input wire logic [7:0] sfr_rdata_i,
    input wire logic sfr_hit_i,
    // pointer use and EEPROM state
    output logic ptr_inc_o,
    output logic eeprom_busy_o
);
    // idle lines at time zero
    initial begin
        sfr_req_o = '{rd: 1'b0, wr: 1'b0, addr: 8'h5A, wdata: 8'hA5};
        ptr_inc_o = 1'b0;
        eeprom_busy_o = 1'b0;
    end

    // one access: drive after a falling edge, hold over the taking edge
    task automatic access(input logic rd, input logic [7:0] addr, input logic [7:0] wdata,
                          output logic [7:0] rdata, output logic hit);
        @(negedge mclk_i);
        sfr_req_o = '{rd: rd, wr: ~rd, addr: addr, wdata: wdata};
        @(negedge mclk_i);
        rdata = sfr_rdata_i;
        hit = sfr_hit_i;
        // released lines show the inverse, not the last value
        sfr_req_o = '{rd: 1'b0, wr: 1'b0, addr: ~addr, wdata: ~wdata};
    endtask

    // one-cycle pointer increment pulse
    task automatic inc();
        @(negedge mclk_i);
        ptr_inc_o = 1'b1;
        @(negedge mclk_i);
        ptr_inc_o = 1'b0;
    endtask

    // EEPROM programming state seen by the block
    task automatic set_busy(input logic b);
        @(negedge mclk_i);
        eeprom_busy_o = b;
    endtask
endmodule
`default_nettype wire

// ===== test/testbench.sv
// self-checking bench for the watchdog / memory control registers
// assumes shortened watchdog base and pin hold counts
`timescale 1ns/1ps
`default_nettype none
module testbench;
    localparam int BASE = 8;
    logic mclk_i = 1'b0;
    logic rst_i = 1'b1;
    logic rst_pin_i = 1'b0;
    logic ce = 1'b1;
    wd_mem_pkg::sfr_req_t sfr_req;
    logic [7:0] sfr_rdata;
    logic sfr_hit, ptr_inc, busy, route, we, sys_reset, power_off_flag;
    logic [15:0] data_pointer;
    logic seen_rst = 1'b0;
    int err_count = 0;
    int tests_run = 0;
    int cycles = 0;

    // 50 MHz clock
    always #10 mclk_i = ~mclk_i;

    wd_mem_regs #(.WD_BASE_CYCLES(BASE), .HOLD_CLKS(4)) wd_mem_regs_i (
        .mclk_i(mclk_i), .rst_i(rst_i), .ce_i(ce), .rst_pin_i(rst_pin_i),
        .sfr_req_i(sfr_req), .sfr_rdata_o(sfr_rdata), .sfr_hit_o(sfr_hit),
        .ptr_inc_i(ptr_inc), .data_pointer_o(data_pointer), .eeprom_busy_i(busy),
        .eeprom_route_o(route), .eeprom_write_enable_o(we),
        .sys_reset_o(sys_reset), .power_off_flag_o(power_off_flag));

    core_model core_model_i (
        .mclk_i(mclk_i), .sfr_req_o(sfr_req), .sfr_rdata_i(sfr_rdata),
        .sfr_hit_i(sfr_hit), .ptr_inc_o(ptr_inc), .eeprom_busy_o(busy));

    // sticky record of any system reset
    always @(posedge mclk_i) if (sys_reset === 1'b1) seen_rst <= 1'b1;

    // hang guard
    always @(posedge mclk_i) begin
        cycles++;
        if (cycles == 12000) begin
            err_count++;
            give_verdict();
        end
    end

    task automatic give_verdict();
        if (err_count == 0 && tests_run > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        tests_run++;
        if (got !== exp) begin
            err_count++;
            $display("MISMATCH at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [7:0] r;
        logic h;
        core_model_i.access(1'b0, a, d, r, h);
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp, input logic hexp);
        logic [7:0] r;
        logic h;
        core_model_i.access(1'b1, a, 8'h00, r, h);
        chk({8'h00, r}, {8'h00, exp});
        chk({15'h0000, h}, {15'h0000, hexp});
    endtask

    task automatic idle(input int n);
        repeat (n) @(negedge mclk_i);
    endtask

    task automatic t_reset_values();
        rd_chk(8'h96, 8'h02, 1'b1);
        for (int a = 8'h82; a <= 8'h85; a++) rd_chk(8'(a), 8'h00, 1'b1);
        rd_chk(8'h87, 8'h10, 1'b1);
        rd_chk(8'h90, 8'h00, 1'b0);
    endtask

    task automatic t_pointers();
        wr(8'h82, 8'h11);
        wr(8'h83, 8'h22);
        wr(8'h84, 8'h33);
        wr(8'h85, 8'h44);
        idle(1);
        chk(data_pointer, 16'h2211);
        wr(8'h96, 8'h04);
        idle(1);
        chk(data_pointer, 16'h4433);
        core_model_i.inc();
        idle(1);
        chk(data_pointer, 16'h4434);
        rd_chk(8'h84, 8'h34, 1'b1);
        rd_chk(8'h82, 8'h11, 1'b1);
        rd_chk(8'h85, 8'h44, 1'b1);
    endtask

    task automatic t_eeprom();
        wr(8'h96, 8'h18);
        idle(1);
        chk({15'h0000, route}, 16'h0001);
        chk({15'h0000, we}, 16'h0001);
        core_model_i.set_busy(1'b1);
        rd_chk(8'h96, 8'h18, 1'b1);
        core_model_i.set_busy(1'b0);
        rd_chk(8'h96, 8'h1A, 1'b1);
        wr(8'h96, 8'h00);
        idle(1);
        chk({15'h0000, route}, 16'h0000);
        chk({15'h0000, we}, 16'h0000);
        core_model_i.set_busy(1'b1);
        wr(8'h96, 8'h02);
        rd_chk(8'h96, 8'h00, 1'b1);
        core_model_i.set_busy(1'b0);
    endtask

    // clock enable low: writes, reads and increments all frozen
    task automatic t_freeze();
        ce = 1'b0;
        rd_chk(8'h85, 8'h00, 1'b0);
        wr(8'h82, 8'hEE);
        core_model_i.inc();
        wr(8'h96, 8'h04);
        ce = 1'b1;
        rd_chk(8'h82, 8'h11, 1'b1);
        idle(1);
        chk(data_pointer, 16'h2211);
    endtask

    task automatic t_watchdog();
        int n;
        int lo;
        logic [2:0] ps;
        for (int p = 0; p < 8; p++) begin
            ps = 3'(p);
            lo = BASE << p;
            n = 0;
            wr(8'h96, {ps, 5'h01});
            while (sys_reset !== 1'b1 && n < 3000) begin
                @(negedge mclk_i);
                n++;
            end
            chk(16'(n >= lo && n <= lo + (1 << p) + 4), 16'h0001);
            idle(3);
            rd_chk(8'h96, 8'h02, 1'b1);
        end
    endtask

    task automatic t_restart();
        seen_rst = 1'b0;
        wr(8'h96, 8'h01);
        repeat (20) wr(8'h96, 8'h03);
        chk({15'h0000, seen_rst}, 16'h0000);
        wr(8'h96, 8'h00);
        idle(40);
        chk({15'h0000, seen_rst}, 16'h0000);
    endtask

    task automatic t_pin();
        wr(8'h87, 8'h00);
        wr(8'h82, 8'h5A);
        wr(8'h96, 8'h0C);
        seen_rst = 1'b0;
        rst_pin_i = 1'b1;
        idle(3);
        rst_pin_i = 1'b0;
        idle(10);
        chk({15'h0000, seen_rst}, 16'h0000);
        rst_pin_i = 1'b1;
        idle(12);
        chk({15'h0000, sys_reset}, 16'h0001);
        rst_pin_i = 1'b0;
        idle(5);
        rd_chk(8'h96, 8'h02, 1'b1);
        rd_chk(8'h82, 8'h00, 1'b1);
        rd_chk(8'h87, 8'h00, 1'b1);
        wr(8'h87, 8'h10);
        idle(1);
        chk({15'h0000, power_off_flag}, 16'h0001);
    endtask

    // main sequence
    initial begin
        idle(3);
        rst_i = 1'b0;
        t_reset_values();
        t_pointers();
        t_eeprom();
        t_freeze();
        t_watchdog();
        t_restart();
        t_pin();
        give_verdict();
    end
endmodule
`default_nettype wire

// ===== verilog/wd_counter.sv
// watchdog counter: base tick of one nominal minimum period, then a
// power-of-two number of ticks chosen by the prescale field
// assumes restart_i and enable_i come from logic on the same clock
`timescale 1ns/1ps
`default_nettype none
module wd_counter #(
    parameter int BASE_CYCLES = wd_mem_pkg::WD_BASE_CYCLES,
    parameter int PS_W = 3
) (
    // clock and control
    input wire logic mclk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    // watchdog control
    input wire logic enable_i,
    input wire logic restart_i,
    input wire logic [PS_W-1:0] prescale_i,
    // expiry pulse
    output logic timeout_o
);
    localparam int TICK_W = 2 ** PS_W;
    localparam int BASE_W = (BASE_CYCLES > 1) ? $clog2(BASE_CYCLES) : 1;

    logic [BASE_W-1:0] base_cnt;
    logic [TICK_W-1:0] ticks;
    logic [TICK_W-1:0] target;

    initial begin
        if (BASE_CYCLES < 1) $error("wd_counter: BASE_CYCLES must be at least 1");
        if (PS_W < 1 || PS_W > 4) $error("wd_counter: PS_W out of range");
    end

    // period is base times two to the prescale
    assign target = TICK_W'(1) << prescale_i;

    // count ticks; a restart or disable clears everything
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            base_cnt <= '0;
            ticks <= '0;
            timeout_o <= 1'b0;
        end else if (ce_i) begin
            if (restart_i || !enable_i || ticks == target) begin
                base_cnt <= '0;
                ticks <= '0;
                timeout_o <= enable_i && !restart_i && ticks == target;
            end else if (base_cnt == BASE_W'(BASE_CYCLES - 1)) begin
                base_cnt <= '0;
                ticks <= ticks + TICK_W'(1);
                timeout_o <= 1'b0;
            end else begin
                base_cnt <= base_cnt + BASE_W'(1);
                timeout_o <= 1'b0;
            end
        end
    end

    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (rst_i);

    property p_period;
        $rose(timeout_o) |-> $past(ticks) == $past(target) && $past(enable_i);
    endproperty
    a_period: assert property (p_period) else $error("watchdog expired off period");

    property p_restart_clears;
        ce_i && restart_i |=> ticks == '0 && base_cnt == '0 && !timeout_o;
    endproperty
    a_restart_clears: assert property (p_restart_clears) else $error("restart left count");

endmodule
`default_nettype wire

// ===== verilog/wd_mem_pkg.sv
// package: addresses, field layout, reset values and timing for the
// watchdog / memory control special-function registers
// assumes a 50 MHz core clock and an 8-bit special-function space
package wd_mem_pkg;

    // special-function addresses
    localparam logic [7:0] ADDR_PTR0_LOW = 8'h82;
    localparam logic [7:0] ADDR_PTR0_HIGH = 8'h83;
    localparam logic [7:0] ADDR_PTR1_LOW = 8'h84;
    localparam logic [7:0] ADDR_PTR1_HIGH = 8'h85;
    localparam logic [7:0] ADDR_POWER_CONTROL = 8'h87;
    localparam logic [7:0] ADDR_WD_MEM_CONTROL = 8'h96;

    // field positions
    localparam int BIT_RESTART = 1;
    localparam int BIT_POWER_OFF = 4;

    // reset values
    localparam logic [7:0] WMC_RESET = 8'h02;
    localparam logic [7:0] PTR_RESET = 8'h00;
    localparam logic POWER_OFF_AT_POWER_UP = 1'b1;

    // timing
    localparam longint CLK_HZ = 50000000;
    localparam int WD_BASE_MS = 16;
    localparam int WD_MAX_MS = 2048;
    localparam int WD_BASE_CYCLES = int'((longint'(WD_BASE_MS) * CLK_HZ) / 1000);
    localparam int MACHINE_CYCLE_CLKS = 12;
    localparam int RESET_HOLD_MC = 2;
    localparam int RESET_HOLD_CLKS = RESET_HOLD_MC * MACHINE_CYCLE_CLKS;

    // watchdog and memory control layout, bit 7 down to bit 0
    typedef struct packed {
        logic [2:0] wd_prescale;
        logic eeprom_write_enable;
        logic eeprom_access_enable;
        logic pointer_select;
        logic wd_restart;
        logic wd_enable;
    } wmc_t;

    // one special-function access from the core
    typedef struct packed {
        logic rd;
        logic wr;
        logic [7:0] addr;
        logic [7:0] wdata;
    } sfr_req_t;

endpackage

// ===== verilog/wd_mem_regs.sv
// watchdog / memory control registers, dual data pointer and power-off
// flag, reached by the core over its special-function access strobes
// assumes rst_i is the power-up reset; the reset pin arrives raw
//
// Overview of operation
// - prescale bits pick 16 to 2048 ms
// - access enable routes pointer moves to EEPROM
// - pointer select picks bank zero or one
// - restart write gives one counter-clearing pulse
// - restart position never reads back restart
// - same position reads EEPROM ready, busy zero
// - enable bit switches watchdog on or off
// - control register at 96H, reset 02H
// - pointer banks at 82H-83H and 84H-85H
// - power-off flag survives system reset
// - reset pin held two machine cycles
`timescale 1ns/1ps
`default_nettype none
module wd_mem_regs #(
    parameter int WD_BASE_CYCLES = wd_mem_pkg::WD_BASE_CYCLES,
    parameter int HOLD_CLKS = wd_mem_pkg::RESET_HOLD_CLKS
) (
    // clock, power-up reset, clock enable
    input wire logic mclk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    // raw reset pin
    input wire logic rst_pin_i,
    // special-function access
    input wire wd_mem_pkg::sfr_req_t sfr_req_i,
    output logic [7:0] sfr_rdata_o,
    output logic sfr_hit_o,
    // core use of the data pointer
    input wire logic ptr_inc_i,
    output logic [15:0] data_pointer_o,
    // external data move routing and EEPROM
    input wire logic eeprom_busy_i,
    output logic eeprom_route_o,
    output logic eeprom_write_enable_o,
    // system reset and power-off flag
    output logic sys_reset_o,
    output logic power_off_flag_o
);
    localparam int HOLD_W = $clog2(HOLD_CLKS + 1);

    wd_mem_pkg::wmc_t wmc;
    logic [15:0] bank0;
    logic [15:0] bank1;
    logic pin_meta;
    logic pin_sync;
    logic [HOLD_W-1:0] hold_cnt;
    logic wd_timeout;
    logic wd_restart;
    logic ctl_reset;
    logic wr_hit;
    logic [7:0] next_rdata;
    logic next_hit;

    initial begin
        if (HOLD_CLKS < 1) $error("wd_mem_regs: HOLD_CLKS must be at least 1");
    end

    assign wr_hit = ce_i && sfr_req_i.wr;
    // control state clears on power-up or any system reset
    assign ctl_reset = rst_i || sys_reset_o;

    assign wd_restart = wr_hit && sfr_req_i.addr == wd_mem_pkg::ADDR_WD_MEM_CONTROL
        && sfr_req_i.wdata[wd_mem_pkg::BIT_RESTART];

    // reset pin synchroniser
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            pin_meta <= 1'b0;
            pin_sync <= 1'b0;
        end else if (ce_i) begin
            pin_meta <= rst_pin_i;
            pin_sync <= pin_meta;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            hold_cnt <= '0;
        end else if (ce_i) begin
            if (!pin_sync) begin
                hold_cnt <= '0;
            end else if (hold_cnt != HOLD_W'(HOLD_CLKS)) begin
                hold_cnt <= hold_cnt + HOLD_W'(1);
            end
        end
    end

    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            sys_reset_o <= 1'b0;
        end else if (ce_i) begin
            sys_reset_o <= (hold_cnt == HOLD_W'(HOLD_CLKS)) || wd_timeout;
        end
    end

    // control register, restart bit always stored as one
    always_ff @(posedge mclk_i) begin
        if (ctl_reset) begin
            wmc <= wd_mem_pkg::WMC_RESET;
        end else if (wr_hit && sfr_req_i.addr == wd_mem_pkg::ADDR_WD_MEM_CONTROL) begin
            wmc <= sfr_req_i.wdata;
            wmc.wd_restart <= 1'b1;
        end
    end

    // pointer banks and increment of selected bank
    always_ff @(posedge mclk_i) begin
        if (ctl_reset) begin
            bank0 <= {wd_mem_pkg::PTR_RESET, wd_mem_pkg::PTR_RESET};
            bank1 <= {wd_mem_pkg::PTR_RESET, wd_mem_pkg::PTR_RESET};
        end else if (ce_i) begin
            if (ptr_inc_i && !wmc.pointer_select) bank0 <= bank0 + 16'h0001;
            if (ptr_inc_i && wmc.pointer_select) bank1 <= bank1 + 16'h0001;
            if (sfr_req_i.wr) begin
                unique case (sfr_req_i.addr)
                    wd_mem_pkg::ADDR_PTR0_LOW: bank0[7:0] <= sfr_req_i.wdata;
                    wd_mem_pkg::ADDR_PTR0_HIGH: bank0[15:8] <= sfr_req_i.wdata;
                    wd_mem_pkg::ADDR_PTR1_LOW: bank1[7:0] <= sfr_req_i.wdata;
                    wd_mem_pkg::ADDR_PTR1_HIGH: bank1[15:8] <= sfr_req_i.wdata;
                    default: ;
                endcase
            end
        end
    end

    // power-off flag, set by power-up or by a write to 87H with bit 4 high
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            power_off_flag_o <= wd_mem_pkg::POWER_OFF_AT_POWER_UP;
        end else if (wr_hit && sfr_req_i.addr == wd_mem_pkg::ADDR_POWER_CONTROL) begin
            power_off_flag_o <= sfr_req_i.wdata[wd_mem_pkg::BIT_POWER_OFF];
        end
    end

    // read multiplexer
    always_comb begin
        next_rdata = 8'h00;
        next_hit = 1'b1;
        unique case (sfr_req_i.addr)
            wd_mem_pkg::ADDR_PTR0_LOW: next_rdata = bank0[7:0];
            wd_mem_pkg::ADDR_PTR0_HIGH: next_rdata = bank0[15:8];
            wd_mem_pkg::ADDR_PTR1_LOW: next_rdata = bank1[7:0];
            wd_mem_pkg::ADDR_PTR1_HIGH: next_rdata = bank1[15:8];
            wd_mem_pkg::ADDR_POWER_CONTROL:
                next_rdata[wd_mem_pkg::BIT_POWER_OFF] = power_off_flag_o;
            wd_mem_pkg::ADDR_WD_MEM_CONTROL: begin
                next_rdata = wmc;
                next_rdata[wd_mem_pkg::BIT_RESTART] = !eeprom_busy_i;
            end
            default: next_hit = 1'b0;
        endcase
    end

    // registered read answer, one cycle after the strobe
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            sfr_rdata_o <= 8'h00;
            sfr_hit_o <= 1'b0;
        end else if (ce_i) begin
            sfr_rdata_o <= sfr_req_i.rd ? next_rdata : 8'h00;
            sfr_hit_o <= sfr_req_i.rd && next_hit;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            data_pointer_o <= 16'h0000;
            eeprom_route_o <= 1'b0;
            eeprom_write_enable_o <= 1'b0;
        end else if (ce_i) begin
            data_pointer_o <= wmc.pointer_select ? bank1 : bank0;
            eeprom_route_o <= wmc.eeprom_access_enable;
            eeprom_write_enable_o <= wmc.eeprom_write_enable;
        end
    end

    wd_counter #(
        .BASE_CYCLES(WD_BASE_CYCLES),
        .PS_W(3)
    ) u_wd (
        .mclk_i(mclk_i),
        .rst_i(ctl_reset),
        .ce_i(ce_i),
        .enable_i(wmc.wd_enable),
        .restart_i(wd_restart),
        .prescale_i(wmc.wd_prescale),
        .timeout_o(wd_timeout)
    );

    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (rst_i);

    sequence s_restart_write;
        wd_restart;
    endsequence
    sequence s_restart_gone;
        !wd_restart ##0 ce_i;
    endsequence
    property p_restart_pulse;
        s_restart_write ##1 ce_i && !wr_hit |-> s_restart_gone;
    endproperty
    a_restart_pulse: assert property (p_restart_pulse) else $error("restart not one pulse");

    property p_ready_read;
        ce_i && sfr_req_i.rd && sfr_req_i.addr == wd_mem_pkg::ADDR_WD_MEM_CONTROL
            |=> sfr_rdata_o[wd_mem_pkg::BIT_RESTART] == !$past(eeprom_busy_i);
    endproperty
    a_ready_read: assert property (p_ready_read) else $error("ready flag wrong");

    property p_ctl_reset;
        sys_reset_o |=> wmc == wd_mem_pkg::WMC_RESET;
    endproperty
    a_ctl_reset: assert property (p_ctl_reset) else $error("control not reset");

    property p_pointer_sel;
        ce_i |=> data_pointer_o == ($past(wmc.pointer_select) ? $past(bank1) : $past(bank0));
    endproperty
    a_pointer_sel: assert property (p_pointer_sel) else $error("wrong pointer bank");

    property p_route;
        ce_i |=> eeprom_route_o == $past(wmc.eeprom_access_enable);
    endproperty
    a_route: assert property (p_route) else $error("move routing wrong");

    property p_disabled;
        ce_i && !wmc.wd_enable |=> !wd_timeout;
    endproperty
    a_disabled: assert property (p_disabled) else $error("disabled watchdog fired");

    property p_pof_keep;
        sys_reset_o && !wr_hit |=> $stable(power_off_flag_o);
    endproperty
    a_pof_keep: assert property (p_pof_keep) else $error("power-off flag disturbed");

    property p_wd_reset;
        ce_i && wd_timeout |=> sys_reset_o;
    endproperty
    a_wd_reset: assert property (p_wd_reset) else $error("no reset on expiry");

    // pin reset only after full hold
    property p_pin_hold;
        $rose(sys_reset_o) && !$past(wd_timeout) |-> $past(hold_cnt) == HOLD_W'(HOLD_CLKS);
    endproperty
    a_pin_hold: assert property (p_pin_hold) else $error("pin reset too early");

    property p_bank1_write;
        wr_hit && sfr_req_i.addr == wd_mem_pkg::ADDR_PTR1_LOW && !ptr_inc_i && !sys_reset_o
            |=> bank1[7:0] == $past(sfr_req_i.wdata);
    endproperty
    a_bank1_write: assert property (p_bank1_write) else $error("bank one write lost");

endmodule
`default_nettype wire
